// ==== design/dmi_map.svh ====
/*
  Constants for the DDR2 initialization and mode register link: timing
  counts, command encodings, field positions and host register offsets.
  Assumes a 50 MHz system clock (20 ns period).
*/
`ifndef DMI_MAP_SVH
`define DMI_MAP_SVH

`define DMI_CLK_PERIOD_NS      20
`define DMI_PWR_WAIT_US        200
`define DMI_PWR_WAIT_CYC       ((`DMI_PWR_WAIT_US * 1000 + `DMI_CLK_PERIOD_NS - 1) / `DMI_CLK_PERIOD_NS)
`define DMI_CKE_WAIT_NS        400
`define DMI_CKE_WAIT_CYC       ((`DMI_CKE_WAIT_NS + `DMI_CLK_PERIOD_NS - 1) / `DMI_CLK_PERIOD_NS)
`define DMI_DLL_WAIT_CLK       200
`define DMI_MODE_WRITE_CYC     2
`define DMI_GAP_CYC            4
`define DMI_MIN_REFRESH        2
`define DMI_MAX_POSTED         8
`define DMI_REFI_CYC           390

// Command encodings {cs_n, ras_n, cas_n, we_n}
`define DMI_CMD_NOP            4'h7
`define DMI_CMD_DESEL          4'h8
`define DMI_CMD_PRE            4'h2
`define DMI_CMD_REF            4'h1
`define DMI_CMD_MRS            4'h0

// Main mode register fields and the precharge all address bit
`define DMI_MR_BL_LO           0
`define DMI_MR_BT              3
`define DMI_MR_CL_LO           4
`define DMI_MR_TM              7
`define DMI_MR_DLLRST          8
`define DMI_MR_WR_LO           9
`define DMI_PRE_ALL_BIT        10

// Extended register 1 calibration field
`define DMI_EMR1_CAL_LO        7

// Host register offsets (byte addresses)
`define DMI_REG_CTRL           12'h000
`define DMI_REG_STATUS         12'h004
`define DMI_REG_MR             12'h008
`define DMI_REG_EMR1           12'h00C
`define DMI_REG_EMR2           12'h010
`define DMI_REG_EMR3           12'h014

`endif

// ==== design/dmi_pkg.sv ====
/*
  Types shared by both ends of the DDR2 initialization link.
  Assumes dmi_map.svh supplies the numeric constants.
*/
package dmi_pkg;
  typedef enum {
    DMI_ST_PWR, DMI_ST_CKE, DMI_ST_PRE1, DMI_ST_EMR2, DMI_ST_EMR3, DMI_ST_EMR1,
    DMI_ST_MRDLL, DMI_ST_PRE2, DMI_ST_REF, DMI_ST_MROP, DMI_ST_DLLW, DMI_ST_CALD,
    DMI_ST_CALX, DMI_ST_RUN, DMI_ST_GAP
  } dmi_state_e;
  typedef logic [3:0] dmi_cmd_t;
endpackage

// ==== design/dmi_link_if.sv ====
/*
  Command and address link between the controller and the DDR2 device.
  Assumes both ends share hclk; there is no clocking block.
*/
`timescale 1ns/1ps
interface dmi_link_if;
  logic        cke;
  logic        odt;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [2:0]  ba;
  logic [13:0] addr;

  modport ctrl (output cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
  modport dev  (input  cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface

// ==== design/dmi_cmd_decode.sv ====
/*
  Decodes a registered command word into its kinds and the mode register
  selected by the two low bank bits. Assumes inputs are already synchronous.
*/
`timescale 1ns/1ps
module dmi_cmd_decode
  import dmi_pkg::*;
(
  input  wire dmi_cmd_t   cmd,
  input  wire logic [2:0] ba,
  output logic            is_mrs,
  output logic            is_ref,
  output logic            is_pre,
  output logic [3:0]      sel
);
`include "dmi_map.svh"
  // Kind decode
  assign is_mrs = (cmd == `DMI_CMD_MRS);
  assign is_ref = (cmd == `DMI_CMD_REF);
  assign is_pre = (cmd == `DMI_CMD_PRE);
  // One-hot register select from both low bank bits; main needs BA2 low too
  assign sel[0] = is_mrs && (ba == 3'h0);               // see R2, see R14
  assign sel[1] = is_mrs && (ba[1:0] == 2'h1);          // see R2
  assign sel[2] = is_mrs && (ba[1:0] == 2'h2);          // see R2
  assign sel[3] = is_mrs && (ba[1:0] == 2'h3);          // see R2
endmodule // dmi_cmd_decode

// ==== design/dmi_device.sv ====
/*
  Device end: samples the command link, stores the four mode registers and
  presents the decoded main register settings. Assumes a controller that follows the
  power-up order; link pins come from another domain, so they pass two
  flip-flops first.
*/
`timescale 1ns/1ps
module dmi_device
  import dmi_pkg::*;
#(
  parameter int ADDR_W = 14
)
(
  input  wire logic    hclk,
  input  wire logic    hresetn,
  input  wire logic    ce,
  dmi_link_if.dev      link,
  output logic [13:0]  mr_value,
  output logic [13:0]  emr1_value,
  output logic [13:0]  emr2_value,
  output logic [13:0]  emr3_value,
  output logic [3:0]   written,
  output logic [2:0]   burst_len,
  output logic         burst_interleave,
  output logic [2:0]   cas_latency,
  output logic         dll_reset_pulse,
  output logic         refresh_pulse,
  output logic         refresh_late
);
`include "dmi_map.svh"
  logic [24:0] s1_r, s2_r;
  logic [13:0] regs_r [4];
  logic [3:0]  written_r;
  logic        dllrst_r, ref_r;
  logic [15:0] refi_cnt_r;
  logic        mrs, rf, pr;
  logic [3:0]  sel;
  logic [13:0] a_masked;

  // Two-stage synchroniser on every link pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= '0;
      s2_r <= '0;
    end else if (ce) begin
      // Exactly 25 bits: cke 24, command 23:20, bank 19:17, address 16:3, odt 2
      s1_r <= {link.cke, link.cs_n, link.ras_n, link.cas_n, link.we_n, link.ba, link.addr,
               link.odt, 2'h0};
      s2_r <= s1_r;
    end
  end

  dmi_cmd_decode u_dec (
    .cmd    (s2_r[23:20]),
    .ba     (s2_r[19:17]),
    .is_mrs (mrs),
    .is_ref (rf),
    .is_pre (pr),
    .sel    (sel)
  );

  // Narrow parts ignore the top address bit
  assign a_masked = (ADDR_W == 14) ? s2_r[16:3] : {1'b0, s2_r[15:3]};   // see R14

  // Whole register is replaced on each write; array untouched
  generate
    for (genvar i = 0; i < 4; i++) begin : g_reg
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) regs_r[i] <= '0;                            // see R13
        else if (ce && s2_r[24] && sel[i]) regs_r[i] <= a_masked; // see R11, see R12
      end
    end
  endgenerate

  // Written flags, DLL reset and refresh events, overdue refresh watch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      written_r  <= '0;
      dllrst_r   <= 1'b0;
      ref_r      <= 1'b0;
      refi_cnt_r <= '0;
    end else if (ce) begin
      written_r  <= written_r | (s2_r[24] ? sel : 4'h0);
      dllrst_r   <= s2_r[24] && sel[0] && a_masked[`DMI_MR_DLLRST];
      ref_r      <= s2_r[24] && rf;
      if (s2_r[24] && rf) refi_cnt_r <= '0;                       // see R1
      else if (refi_cnt_r != 16'hFFFF) refi_cnt_r <= refi_cnt_r + 16'h0001;
    end
  end

  // Register values, decoded main register fields and event outputs
  assign mr_value         = regs_r[0];
  assign emr1_value       = regs_r[1];   // see R19
  assign emr2_value       = regs_r[2];
  assign emr3_value       = regs_r[3];
  assign written          = written_r;
  assign burst_len        = regs_r[0][`DMI_MR_BL_LO +: 3];              // see R17
  assign burst_interleave = regs_r[0][`DMI_MR_BT];                      // see R20
  assign cas_latency      = regs_r[0][`DMI_MR_CL_LO +: 3];              // see R17
  assign dll_reset_pulse  = dllrst_r;                                   // see R18
  assign refresh_pulse    = ref_r;
  assign refresh_late     =
    (refi_cnt_r > 16'((`DMI_MAX_POSTED + 1) * `DMI_REFI_CYC)) && written_r[0]; // see R1
endmodule // dmi_device

// ==== design/dmi_ctrl.sv ====
/*
  Controller end: runs the DDR2 power-up sequence on the command link and
  offers software an AHB-Lite slave holding the values it writes.
  Assumes a single hclk domain shared with the link and zero-wait OKAY replies.
*/
// The placing of the registers and register access over AHB-Lite were decided locally.
// Behaviour
// R1: refresh gap never above nine intervals
// R2: two low bank bits pick register
// R3: all four registers written, any order
// R4: CKE and ODT low during power-up
// R5: wait 200 us, then NOP and CKE high
// R6: 400 ns of NOP, then precharge all
// R7: write EMR2, EMR3, EMR1 DLL on, MR reset
// R8: precharge all, then two or more refreshes
// R9: main register written with A8 low
// R10: calibration default then exit, 200 clocks late
// R11: every write carries whole register value
// R12: register writes keep array contents
// R13: main register undefined until programmed
// R14: main write needs all bank bits low
// R15: writes only with banks precharged, CKE high
// R16: wait mode write cycle time after write
// R17: burst length, type, CAS latency fields
// R18: test bit low, A8 DLL reset, WR
// R19: extended and main registers hold settings
// R20: burst type zero sequential, one interleaved
// R21: only NOP between sequence commands
`timescale 1ns/1ps
`include "dmi_map.svh"
module dmi_ctrl
  import dmi_pkg::*;
#(
  parameter int PWR_WAIT = `DMI_PWR_WAIT_CYC,
  parameter int REFI     = `DMI_REFI_CYC
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  dmi_link_if.ctrl         link,
  output logic             init_done
);
  dmi_state_e  st_r, st_nxt, ret_r;
  logic [15:0] cnt_r;
  logic [8:0]  dll_cnt_r;
  logic [15:0] refi_r;
  logic [1:0]  ref_n_r;
  logic        start_r, cke_r;
  logic [3:0]  cmd_r;
  logic [2:0]  ba_r;
  logic [13:0] a_r;
  logic [13:0] mr_r, emr1_r, emr2_r, emr3_r;
  logic        wr_pend_r;
  logic [11:0] waddr_r;
  logic [31:0] rdata;
  logic        ahb_go, cnt_zero, dll_ok, ref_due;
  dmi_cmd_t    issue_cmd;
  logic [2:0]  issue_ba;
  logic [13:0] issue_a;

  // AHB-Lite slave: always ready, always OKAY
  assign ahb_go    = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rdata =
    (haddr == `DMI_REG_CTRL)   ? {31'h0, start_r} :
    (haddr == `DMI_REG_STATUS) ? {27'h0, 5'(st_r == DMI_ST_RUN ? 5'h1F : 5'h00)} :
    (haddr == `DMI_REG_MR)     ? {18'h0, mr_r}   :
    (haddr == `DMI_REG_EMR1)   ? {18'h0, emr1_r} :
    (haddr == `DMI_REG_EMR2)   ? {18'h0, emr2_r} :
    (haddr == `DMI_REG_EMR3)   ? {18'h0, emr3_r} : 32'h0;

  // Address phase latch, read data, write into the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      waddr_r   <= '0;
      hrdata    <= '0;
      start_r   <= 1'b0;
      mr_r      <= '0;
      emr1_r    <= '0;
      emr2_r    <= '0;
      emr3_r    <= '0;
    end else if (ce) begin
      wr_pend_r <= ahb_go && hwrite;
      waddr_r   <= haddr;
      if (ahb_go && !hwrite) hrdata <= rdata;
      if (wr_pend_r) begin
        unique case (waddr_r)
          `DMI_REG_CTRL: start_r <= hwdata[0];
          `DMI_REG_MR:   mr_r    <= hwdata[13:0] & ~14'h0180;  // see R18
          `DMI_REG_EMR1: emr1_r  <= hwdata[13:0] & ~14'h0380;
          `DMI_REG_EMR2: emr2_r  <= hwdata[13:0];
          `DMI_REG_EMR3: emr3_r  <= hwdata[13:0];
          default: ;
        endcase
      end
    end
  end

  assign cnt_zero = (cnt_r == 16'h0);
  assign dll_ok   = (dll_cnt_r >= 9'(`DMI_DLL_WAIT_CLK));
  assign ref_due  = (refi_r >= 16'(REFI));

  // Command chosen in each issuing state; full register value every time
  always_comb begin
    issue_cmd = `DMI_CMD_NOP;
    issue_ba  = 3'h0;
    issue_a   = 14'h0;
    unique case (st_r)
      DMI_ST_PRE1, DMI_ST_PRE2: begin
        issue_cmd = `DMI_CMD_PRE;
        issue_a   = 14'(1 << `DMI_PRE_ALL_BIT);                     // see R6, see R8
      end
      DMI_ST_EMR2: begin issue_cmd = `DMI_CMD_MRS; issue_ba = 3'h2; issue_a = emr2_r; end // see R7
      DMI_ST_EMR3: begin issue_cmd = `DMI_CMD_MRS; issue_ba = 3'h3; issue_a = emr3_r; end
      DMI_ST_EMR1: begin issue_cmd = `DMI_CMD_MRS; issue_ba = 3'h1; issue_a = emr1_r; end
      DMI_ST_MRDLL: begin
        issue_cmd = `DMI_CMD_MRS;
        issue_a   = mr_r | 14'(1 << `DMI_MR_DLLRST);                // see R7, see R14
      end
      DMI_ST_REF: issue_cmd = `DMI_CMD_REF;
      DMI_ST_MROP: begin issue_cmd = `DMI_CMD_MRS; issue_a = mr_r; end   // see R9, see R11
      DMI_ST_CALD: begin
        issue_cmd = `DMI_CMD_MRS;
        issue_ba  = 3'h1;
        issue_a   = emr1_r | 14'(7 << `DMI_EMR1_CAL_LO);            // see R10
      end
      DMI_ST_CALX: begin issue_cmd = `DMI_CMD_MRS; issue_ba = 3'h1; issue_a = emr1_r; end
      DMI_ST_RUN: if (ref_due) issue_cmd = `DMI_CMD_REF;            // see R1
      default: ;
    endcase
  end

  // Sequence order; every issue before DMI_ST_RUN goes through a NOP gap
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      DMI_ST_PWR:   if (start_r && cnt_zero) st_nxt = DMI_ST_CKE;   // see R5
      DMI_ST_CKE:   if (cnt_zero) st_nxt = DMI_ST_PRE1;             // see R6
      DMI_ST_DLLW:  if (dll_ok) st_nxt = DMI_ST_CALD;               // see R10
      DMI_ST_RUN:   st_nxt = DMI_ST_RUN;
      DMI_ST_GAP:   if (cnt_zero) st_nxt = ret_r;                   // see R16, see R21
      default:      st_nxt = DMI_ST_GAP;
    endcase
  end

  // State, counters and link drive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= DMI_ST_PWR;  ret_r <= DMI_ST_PWR;
      cnt_r <= 16'(PWR_WAIT);  dll_cnt_r <= '0;  refi_r <= '0;  ref_n_r <= '0;
      cke_r <= 1'b0;  cmd_r <= `DMI_CMD_NOP;  ba_r <= '0;  a_r <= '0;
    end else if (ce) begin
      st_r  <= st_nxt;
      cmd_r <= issue_cmd;   // see R21
      ba_r  <= issue_ba;
      a_r   <= issue_a;
      if (!cnt_zero && (st_r != DMI_ST_PWR || start_r)) cnt_r <= cnt_r - 16'h1;
      if (st_r == DMI_ST_PWR && st_nxt == DMI_ST_CKE) begin
        cke_r <= 1'b1;                                              // see R4, see R5
        cnt_r <= 16'(`DMI_CKE_WAIT_CYC);
      end
      if (st_r == DMI_ST_MRDLL) dll_cnt_r <= '0;
      else if (!dll_ok) dll_cnt_r <= dll_cnt_r + 9'h1;
      if (issue_cmd == `DMI_CMD_REF) refi_r <= '0;
      else if (cke_r) refi_r <= refi_r + 16'h1;
      if (st_nxt == DMI_ST_GAP && st_r != DMI_ST_GAP) begin
        cnt_r <= 16'(`DMI_GAP_CYC);      // covers the mode write cycle time, see R16
        unique case (st_r)
          DMI_ST_PRE1:  ret_r <= DMI_ST_EMR2;                       // see R3, see R7
          DMI_ST_EMR2:  ret_r <= DMI_ST_EMR3;
          DMI_ST_EMR3:  ret_r <= DMI_ST_EMR1;
          DMI_ST_EMR1:  ret_r <= DMI_ST_MRDLL;
          DMI_ST_MRDLL: ret_r <= DMI_ST_PRE2;                       // see R8, see R15
          DMI_ST_PRE2:  ret_r <= DMI_ST_REF;
          DMI_ST_REF: begin
            ref_n_r <= ref_n_r + 2'h1;
            ret_r   <= (ref_n_r == 2'(`DMI_MIN_REFRESH - 1)) ? DMI_ST_MROP : DMI_ST_REF;
          end
          DMI_ST_MROP:  ret_r <= DMI_ST_DLLW;
          DMI_ST_CALD:  ret_r <= DMI_ST_CALX;
          default:      ret_r <= DMI_ST_RUN;
        endcase
      end
    end
  end

  assign link.cke   = cke_r;
  assign link.odt   = 1'b0;                                         // see R4
  assign link.cs_n  = cmd_r[3];
  assign link.ras_n = cmd_r[2];
  assign link.cas_n = cmd_r[1];
  assign link.we_n  = cmd_r[0];
  assign link.ba    = ba_r;
  assign link.addr  = a_r;
  assign init_done  = (st_r == DMI_ST_RUN);
endmodule // dmi_ctrl

// ==== tb/dmi_link_assertions.sv ====
/*
  Checker for the controller end of the DDR2 initialization link.
  Assumes one hclk domain and link signals taken straight from the interface.
*/
`timescale 1ns/1ps
`include "dmi_map.svh"
module dmi_link_assertions #(
  parameter int PWR_WAIT = `DMI_PWR_WAIT_CYC,
  parameter int REFI     = `DMI_REFI_CYC
)
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        cke,
  input wire logic        odt,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [2:0]  ba,
  input wire logic [13:0] addr
);
  // Command word; act is anything other than NOP or deselect
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire       act = !cs_n && (cmd != `DMI_CMD_NOP);
  wire       mrs = act && (cmd == `DMI_CMD_MRS);
  wire       rfs = act && (cmd == `DMI_CMD_REF);
  int        n_cmd, pwr_cnt, cke_cnt, dll_cnt, gap;
  logic      ref_seen;

  // Sequence position and elapsed times; counts other than gap saturate so they never wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_cmd    <= 0;
      pwr_cnt  <= 0;
      cke_cnt  <= 0;
      dll_cnt  <= 0;
      gap      <= 0;
      ref_seen <= 1'b0;
    end else begin
      n_cmd    <= n_cmd + int'(act && n_cmd < 15);
      pwr_cnt  <= pwr_cnt + int'(pwr_cnt < PWR_WAIT);
      cke_cnt  <= cke_cnt + int'(cke && cke_cnt < 100);
      dll_cnt  <= dll_cnt + int'(n_cmd >= 5 && dll_cnt < 1000);
      gap      <= rfs ? 0 : gap + int'(ref_seen);
      ref_seen <= ref_seen | rfs;
    end
  end

  // Bank bits expected on each mode write of the power-up order
  function automatic logic [2:0] mrs_ba(int n);
    case (n)
      1: return 3'h2;
      2: return 3'h3;
      3, 9, 10: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_odt_low; !odt; endproperty
  a_odt_low: assert property (p_odt_low)
    else $error("odt driven high");
  property p_cke_hold; !$fell(cke); endproperty
  a_cke_hold: assert property (p_cke_hold)
    else $error("cke dropped");
  property p_pwr_wait; $rose(cke) |-> pwr_cnt >= PWR_WAIT && !act; endproperty
  a_pwr_wait: assert property (p_pwr_wait)
    else $error("cke raised too early");
  property p_quiet; act |-> cke && cke_cnt >= `DMI_CKE_WAIT_CYC; endproperty
  a_quiet: assert property (p_quiet)
    else $error("command inside cke settle time");
  property p_pre_all; act && (n_cmd == 0 || n_cmd == 5) |-> cmd == `DMI_CMD_PRE && addr[10];
  endproperty
  a_pre_all: assert property (p_pre_all)
    else $error("precharge all missing");
  property p_init_order;
    act && n_cmd inside {[1:4]} |-> mrs && ba == mrs_ba(n_cmd) && (n_cmd != 4 || addr[8]);
  endproperty
  a_init_order: assert property (p_init_order)
    else $error("mode write order wrong");
  property p_refresh; act && n_cmd inside {6, 7} |-> rfs; endproperty
  a_refresh: assert property (p_refresh)
    else $error("refresh missing");
  property p_op_mode; act && n_cmd == 8 |-> mrs && ba == 3'h0 && !addr[8]; endproperty
  a_op_mode: assert property (p_op_mode)
    else $error("operating mode write wrong");
  property p_cal;
    act && n_cmd inside {9, 10} |-> mrs && ba == 3'h1 && dll_cnt >= 199
      && addr[9:7] == (n_cmd == 9 ? 3'h7 : 3'h0);
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration writes wrong");
  property p_spacing; act |=> !act [*4]; endproperty
  a_spacing: assert property (p_spacing)
    else $error("commands too close");
  property p_test_mode; mrs && ba == 3'h0 |-> !addr[7]; endproperty
  a_test_mode: assert property (p_test_mode)
    else $error("test mode bit set");
  property p_main_bank; mrs && ba[1:0] == 2'h0 |-> !ba[2]; endproperty
  a_main_bank: assert property (p_main_bank)
    else $error("main write with bank bit two");
  property p_ref_gap; gap <= 9 * REFI; endproperty
  a_ref_gap: assert property (p_ref_gap)
    else $error("refresh gap too long");
endmodule // dmi_link_assertions

// ==== tb/tb_ddr2_init_mode_register.sv ====
/*
  Bench joining controller and device through the link interface.
  Assumes the design header, package and modules are compiled first.
*/
`timescale 1ns/1ps
`include "dmi_map.svh"
module tb_ddr2_init_mode_register;
  localparam int PWR = 50;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} dmi_row_s;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [11:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        init_done;
  logic [13:0] mr_v, emr1_v, emr2_v, emr3_v;
  logic [3:0]  written;
  logic [2:0]  blen, cl;
  logic        bint, dll_p, ref_p, late;
  int          errors, tests_run, dll_n, ref_n, n;
  // Write, then read back; held bits come back cleared, unmapped reads 0
  dmi_row_s    rows [9] = '{
    '{12'h008, 32'hFFFF_FFFF, 32'h0000_3E7F}, '{12'h00C, 32'hFFFF_FFFF, 32'h0000_3C7F},
    '{12'h010, 32'hFFFF_FFFF, 32'h0000_3FFF}, '{12'h014, 32'hFFFF_FFFF, 32'h0000_3FFF},
    '{12'h018, 32'hFFFF_FFFF, 32'h0000_0000}, '{12'h008, 32'h0000_044A, 32'h0000_044A},
    '{12'h00C, 32'h0000_0044, 32'h0000_0044}, '{12'h010, 32'h0000_0000, 32'h0000_0000},
    '{12'h014, 32'h0000_0000, 32'h0000_0000}};

  dmi_link_if link_i ();
  dmi_ctrl #(.PWR_WAIT(PWR)) dmi_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .link(link_i), .init_done(init_done));
  dmi_device dmi_device_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .link(link_i), .mr_value(mr_v),
    .emr1_value(emr1_v), .emr2_value(emr2_v), .emr3_value(emr3_v), .written(written),
    .burst_len(blen), .burst_interleave(bint), .cas_latency(cl), .dll_reset_pulse(dll_p),
    .refresh_pulse(ref_p), .refresh_late(late));
  dmi_link_assertions #(.PWR_WAIT(PWR), .REFI(`DMI_REFI_CYC)) dmi_link_assertions_i (
    .hclk(hclk), .hresetn(hresetn), .cke(link_i.cke), .odt(link_i.odt), .cs_n(link_i.cs_n),
    .ras_n(link_i.ras_n), .cas_n(link_i.cas_n), .we_n(link_i.we_n), .ba(link_i.ba),
    .addr(link_i.addr));

  // Compare and count; a mismatch is reported at once
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Single word transfer; entered just after a rising edge
  // Waits are open ended; only the watchdog ends a stuck transfer
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic complete_run();
    $display("errors %0d of %0d checks", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Pulse tallies restart with every reset of the design
  always @(posedge hclk) begin
    dll_n <= hresetn ? dll_n + int'(dll_p === 1'b1) : 0;
    ref_n <= hresetn ? ref_n + int'(ref_p === 1'b1) : 0;
  end

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // Two passes of the whole run take near 6600 cycles
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    complete_run();
  end

  // Second pass follows a reset in mid-run, so re-initialization is exercised
  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 12'h000;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    for (int p = 0; p < 2; p++) begin
      hresetn <= 1'b1;
      @(posedge hclk);
      check(32'(mr_v), 32'h0);
      check(32'(written), 32'h0);
      check(32'(link_i.cke), 32'h0);
      for (int i = 0; i < 9; i++) begin
        bus(1'b1, rows[i].a, rows[i].w);
        bus(1'b0, rows[i].a, 32'h0);
        check(rd, rows[i].e);
      end
      bus(1'b1, `DMI_REG_CTRL, 32'h1);
      n = 0;
      while (init_done !== 1'b1 && n < 5000) begin
        @(posedge hclk);
        n++;
      end
      check(32'(init_done), 32'h1);
      bus(1'b0, `DMI_REG_STATUS, 32'h0);
      check(rd, 32'h1F);
      repeat (8) @(posedge hclk);
      check(32'(mr_v), 32'h044A);
      check(32'(emr1_v), 32'h0044);
      check(32'({emr2_v, emr3_v}), 32'h0);
      check(32'(written), 32'hF);
      check(32'({blen, bint, cl}), 32'h0000_0020 | 32'h0000_0008 | 32'h0000_0004);
      check(32'(dll_n), 32'h1);
      check(32'(ref_n >= 2), 32'h1);
      repeat (2400) @(posedge hclk);
      check(32'(late), 32'h0);
      check(32'(ref_n >= 7), 32'h1);
      // Low clock enable must hold off the refresh that would fall due
      while (ref_p !== 1'b1) @(posedge hclk);
      repeat (2) @(posedge hclk);
      ce <= 1'b0;
      n = ref_n;
      repeat (400) @(posedge hclk);
      check(32'(ref_n), 32'(n));
      check(32'(init_done), 32'h1);
      ce <= 1'b1;
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
    end
    complete_run();
  end
endmodule // tb_ddr2_init_mode_register
